// *** add_instruction_execute_tb.sv ***
/*
 * add_instruction_execute_tb: apb and instruction bench for aie_core.
 * assumes aie_partner models fetch and data memory.
 */
`timescale 1ns/1ps
module add_instruction_execute_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] fetch_word = 16'h0000;
    logic fetch_valid = 1'b0;
    logic [15:0] instr_word;
    logic instr_valid;
    logic pc_step;
    logic mem_re;
    logic mem_we;
    logic [3:0] quarter;
    logic [11:0] mem_addr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic [7:0] acc;
    logic [4:0] flags;
    int err_count = 0;
    int n_compared = 0;
    logic [7:0] m_acc = 8'h00;
    logic [4:0] m_flg = 5'h00;
    logic m_run = 1'b0;
    logic [15:0] m_pc = 16'h0000;
    logic [15:0] m_last = 16'h0000;
    logic [31:0] rd;
    logic rerr;
    // literal corners: carry, half-carry, zero, overflow, sign
    logic [7:0] lits [6] = '{8'h15, 8'hdb, 8'h80, 8'h80, 8'hff, 8'h0f};

    // free-running 100 MHz clock
    always #5 pclk = ~pclk;

    aie_core #(.BANK_W(4)) dut (.pclk(pclk), .presetn(presetn),
        .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .instr_word(instr_word),
        .instr_valid(instr_valid), .pc_step(pc_step), .quarter(quarter),
        .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .acc(acc),
        .flags(flags));

    aie_partner pm (.pclk(pclk), .quarter(quarter),
        .fetch_word(fetch_word), .fetch_valid(fetch_valid),
        .instr_word(instr_word), .instr_valid(instr_valid),
        .mem_addr(mem_addr), .mem_re(mem_re), .mem_we(mem_we),
        .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    task automatic chk(input string what, input logic [31:0] seen,
        input logic [31:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    // a wait that runs out ends the run at once
    task automatic hung(input string what);
        err_count++;
        $display("[FAIL] %s expected done seen timeout", what);
        summarize();
    endtask

    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] wd);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
                break;
        end
        if (i == 8)
            hung("pready");
        rd = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // one instruction; ea is the data address the rules give
    task automatic exec(input logic [15:0] w, input logic [11:0] ea);
        logic lit;
        logic fil;
        logic ok;
        logic wf;
        logic cy;
        logic [7:0] b;
        logic [8:0] s;
        logic [4:0] h;
        logic [4:0] ef;
        int i;
        lit = w[15:8] == 8'h0f;
        fil = w[15:11] == 5'b00100;
        ok = (lit | fil) & m_run;
        wf = ok & fil & w[9];
        cy = fil & ~w[10] & m_flg[0];
        b = lit ? w[7:0] : pm.mem[ea];
        s = {1'b0, m_acc} + {1'b0, b} + 9'(cy);
        h = {1'b0, m_acc[3:0]} + {1'b0, b[3:0]} + 5'(cy);
        ef = {s[7], m_acc[7] == b[7] && s[7] != m_acc[7],
            s[7:0] == 8'h00, h[4], s[8]};
        @(posedge pclk);
        fetch_word <= w;
        fetch_valid <= 1'b1;
        for (i = 0; i < 8; i++)
        begin
            @(posedge pclk);
            if (quarter === 4'b0001)
                break;
        end
        if (i == 8)
            hung("quarter");
        fetch_valid <= 1'b0;
        @(posedge pclk);
        chk("mem_re", 32'(mem_re), 32'(ok & fil));
        if (ok & fil)
            chk("mem_addr", 32'(mem_addr), 32'(ea));
        repeat (2) @(posedge pclk);
        chk("pc_step", 32'(pc_step), 32'(ok));
        chk("mem_we", 32'(mem_we), 32'(wf));
        if (wf)
            chk("mem_wdata", 32'(mem_wdata), 32'(s[7:0]));
        #1;
        if (ok)
        begin
            m_acc = wf ? m_acc : s[7:0];
            m_flg = ef;
            m_pc++;
            m_last = w;
        end
        chk("acc", 32'(acc), 32'(m_acc));
        chk("flags", 32'(flags), 32'(m_flg));
    endtask

    initial
    begin
        repeat (16) @(posedge pclk);
        chk("rst quarter", 32'(quarter), 32'h1);
        chk("rst acc", 32'(acc), 32'h0);
        presetn <= 1'b1;
        apb(1'b1, aie_pkg::REG_CTRL, 32'h0000_0201);
        m_run = 1'b1;
        apb(1'b1, aie_pkg::REG_ACC, 32'h10);
        m_acc = 8'h10;
        foreach (lits[i])
            exec({8'h0f, lits[i]}, 12'h000);
        $display("test literal done");
        pm.mem[12'h234] = 8'hc2;
        apb(1'b1, aie_pkg::REG_ACC, 32'h17);
        m_acc = 8'h17;
        exec(16'h2734, 12'h234);
        exec(16'h2534, 12'h234);
        apb(1'b1, aie_pkg::REG_FLAGS, 32'h1);
        m_flg = 5'h01;
        apb(1'b1, aie_pkg::REG_ACC, 32'h4d);
        m_acc = 8'h4d;
        pm.mem[12'hf70] = 8'h02;
        pm.mem[12'h010] = 8'hff;
        exec(16'h2070, 12'hf70);
        exec(16'h2210, 12'h010);
        $display("test file add done");
        apb(1'b1, aie_pkg::REG_INDEX, 32'h300);
        apb(1'b1, aie_pkg::REG_CTRL, 32'h0000_0203);
        pm.mem[12'h35f] = 8'h7f;
        pm.mem[12'hf60] = 8'h01;
        pm.mem[12'h25f] = 8'h33;
        exec(16'h245f, 12'h35f);
        exec(16'h2660, 12'hf60);
        exec(16'h255f, 12'h25f);
        $display("test indexed done");
        exec(16'h0e55, 12'h000);
        exec(16'h2834, 12'h000);
        apb(1'b1, aie_pkg::REG_CTRL, 32'h0);
        m_run = 1'b0;
        exec(16'h0f01, 12'h000);
        $display("test refused done");
        apb(1'b0, aie_pkg::REG_ACC, 32'h0);
        chk("acc read", rd, 32'(m_acc));
        apb(1'b0, aie_pkg::REG_PC, 32'h0);
        chk("pc count", rd, 32'(m_pc));
        apb(1'b0, aie_pkg::REG_LAST, 32'h0);
        chk("last word", rd, 32'(m_last));
        apb(1'b0, 8'h18, 32'h0);
        chk("unmapped err", 32'(rerr), 32'h1);
        chk("unmapped data", rd, 32'h0);
        $display("test registers done");
        summarize();
    end
endmodule

// *** aie_adder.sv ***
/*
 * aie_adder: 8-bit adder with carry in and the five arithmetic flags.
 * purely combinational; the caller registers the results.
 */
`timescale 1ns/1ps
module aie_adder
(
    // operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // results
    output logic [7:0] sum,
    output logic [4:0] flags
);
    logic [8:0] full;
    logic [4:0] low;

    // flags follow the unsigned and two's complement views of the same sum
    assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign low = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign sum = full[7:0];
    assign flags[aie_pkg::FLAG_C] = full[8];
    assign flags[aie_pkg::FLAG_DC] = low[4];
    assign flags[aie_pkg::FLAG_Z] = (full[7:0] == 8'h00);
    assign flags[aie_pkg::FLAG_OV] = (a[7] == b[7]) && (full[7] != a[7]);
    assign flags[aie_pkg::FLAG_N] = full[7];
endmodule

// *** aie_core.sv ***
/*
 * aie_core: executes the three add instructions over four quarters,
 * with an APB register file for control, accumulator and flags.
 * assumes the fetch unit holds instr_word/instr_valid during quarter one
 * and the data memory answers mem_rdata in the cycle mem_re is high.
 */
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
// Operation
// - literal add into accumulator, flags updated
// - literal add opcode upper byte 0000 1111
// - literal add: decode, read, compute, write
// - file add sums accumulator and data byte
// - carry add also adds current carry flag
// - destination bit: 0 accumulator, 1 file
// - bank bit: 0 access, 1 bank pointer
// - extended set, bank 0, f<=95: indexed
// - file add: decode, read, compute, write
module aie_core
#(
    parameter int BANK_W = 4
)
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // instruction fetch
    input wire logic [15:0] instr_word,
    input wire logic instr_valid,
    output logic pc_step,
    output logic [3:0] quarter,
    // data memory
    output logic [11:0] mem_addr,
    output logic mem_re,
    output logic mem_we,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // architectural state
    output logic [7:0] acc,
    output logic [4:0] flags
);
    if (BANK_W < 1 || BANK_W > 4)
        $error("BANK_W must lie between 1 and 4");

    aie_pkg::aie_quarter_t state;
    logic run;
    logic ext_en;
    logic [BANK_W-1:0] bank_pointer;
    logic [11:0] index_base;
    logic [15:0] pc_count;
    logic [15:0] cur_word;
    logic live;
    logic [7:0] operand;
    logic [7:0] res;
    logic [4:0] res_flags;
    logic to_acc;

    // decode: quarter one looks at the fetch port, later the held word
    logic [15:0] dw;
    logic literal_add_op;
    logic file_add_op;
    logic file_add_carry_op;
    logic is_add;
    logic is_file;
    logic issue;
    logic [7:0] fa;
    logic [11:0] eff_addr;
    assign dw = (state == aie_pkg::Q1) ? instr_word : cur_word;
    assign literal_add_op =
        dw[aie_pkg::OPC_HI:aie_pkg::OPC_LO8] == aie_pkg::OP_LIT;
    assign file_add_op =
        dw[aie_pkg::OPC_HI:aie_pkg::OPC_LO6] == aie_pkg::OP_FADD;
    assign file_add_carry_op =
        dw[aie_pkg::OPC_HI:aie_pkg::OPC_LO6] == aie_pkg::OP_FADDC;
    assign is_file = file_add_op | file_add_carry_op;
    assign is_add = literal_add_op | is_file;
    assign issue = (state == aie_pkg::Q1) && run && instr_valid && is_add;
    assign fa = dw[7:0];

    // data address: indexed, access bank or bank pointer
    logic idx_mode;
    logic [11:0] bank_addr;
    logic [11:0] access_addr;
    assign idx_mode = !dw[aie_pkg::BANKSEL_BIT] && ext_en
        && (fa <= aie_pkg::INDEX_LIMIT);
    assign bank_addr = 12'({bank_pointer, fa});
    assign access_addr = (fa < aie_pkg::ACCESS_SPLIT) ? {4'h0, fa}
        : {aie_pkg::ACCESS_HI_BANK, fa};
    assign eff_addr = idx_mode ? 12'(index_base + {4'h0, fa})
        : dw[aie_pkg::BANKSEL_BIT] ? bank_addr : access_addr;

    // adder sees carry only for the carry form
    logic [7:0] sum;
    logic [4:0] sum_flags;
    logic cin;
    assign cin = file_add_carry_op & flags[aie_pkg::FLAG_C];
    aie_adder u_adder
    (
        .a(acc),
        .b(operand),
        .cin(cin),
        .sum(sum),
        .flags(sum_flags)
    );

    // apb decode; zero wait states, pready raised in the access phase
    logic setup;
    logic wr_go;
    logic hit;
    logic [31:0] rd_mux;
    assign setup = psel && !penable && !pready;
    assign wr_go = psel && penable && pready && pwrite;
    assign hit = (paddr == aie_pkg::REG_CTRL) || (paddr == aie_pkg::REG_ACC)
        || (paddr == aie_pkg::REG_FLAGS) || (paddr == aie_pkg::REG_INDEX)
        || (paddr == aie_pkg::REG_PC) || (paddr == aie_pkg::REG_LAST);
    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (paddr)
            aie_pkg::REG_CTRL:
            begin
                rd_mux[aie_pkg::CTRL_RUN] = run;
                rd_mux[aie_pkg::CTRL_EXT] = ext_en;
                rd_mux[aie_pkg::CTRL_BANK_LO +: BANK_W] = bank_pointer;
            end
            aie_pkg::REG_ACC: rd_mux[7:0] = acc;
            aie_pkg::REG_FLAGS: rd_mux[4:0] = flags;
            aie_pkg::REG_INDEX: rd_mux[11:0] = index_base;
            aie_pkg::REG_PC: rd_mux[15:0] = pc_count;
            aie_pkg::REG_LAST: rd_mux[15:0] = cur_word;
            default: rd_mux = 32'h0000_0000;
        endcase
    end

    // bus answer registered so every output comes from a flop
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            pready <= 1'b0;
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= setup;
            prdata <= setup ? rd_mux : 32'h0000_0000;
            pslverr <= setup && !hit;
        end
    end

    // control registers, software only
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            run <= 1'b0;
            ext_en <= 1'b0;
            bank_pointer <= '0;
            index_base <= aie_pkg::INDEX_RST;
        end
        else if (wr_go && paddr == aie_pkg::REG_CTRL)
        begin
            run <= pwdata[aie_pkg::CTRL_RUN];
            ext_en <= pwdata[aie_pkg::CTRL_EXT];
            bank_pointer <= pwdata[aie_pkg::CTRL_BANK_LO +: BANK_W];
        end
        else if (wr_go && paddr == aie_pkg::REG_INDEX)
            index_base <= pwdata[11:0];
    end

    // quarter sequencer, one quarter per clock
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state <= aie_pkg::Q1;
        else
        begin
            case (state)
                aie_pkg::Q1: state <= aie_pkg::Q2;
                aie_pkg::Q2: state <= aie_pkg::Q3;
                aie_pkg::Q3: state <= aie_pkg::Q4;
                aie_pkg::Q4: state <= aie_pkg::Q1;
                default: state <= aie_pkg::Q1;
            endcase
        end
    end
    assign quarter = state;

    // q1 decode and read request, q2 operand, q3 compute
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cur_word <= 16'h0000;
            live <= 1'b0;
            mem_addr <= 12'h000;
            mem_re <= 1'b0;
            operand <= 8'h00;
            res <= 8'h00;
            res_flags <= aie_pkg::FLAGS_RST;
            to_acc <= 1'b0;
            mem_we <= 1'b0;
            mem_wdata <= 8'h00;
            pc_step <= 1'b0;
        end
        else
        begin
            mem_re <= 1'b0;
            mem_we <= 1'b0;
            pc_step <= 1'b0;
            case (state)
                aie_pkg::Q1:
                begin
                    live <= issue;
                    if (issue)
                        cur_word <= instr_word;
                    if (issue && is_file)
                    begin
                        mem_addr <= eff_addr;
                        mem_re <= 1'b1;
                    end
                end
                aie_pkg::Q2:
                    operand <= literal_add_op ? fa : mem_rdata;
                aie_pkg::Q3:
                    if (live)
                    begin
                        res <= sum;
                        res_flags <= sum_flags;
                        to_acc <= literal_add_op
                            || !cur_word[aie_pkg::DEST_BIT];
                        mem_we <= is_file
                            && cur_word[aie_pkg::DEST_BIT];
                        mem_wdata <= sum;
                        pc_step <= 1'b1;
                    end
                default: live <= live;
            endcase
        end
    end

    // q4 commit; a core write beats a software write in the same edge
    logic commit;
    assign commit = (state == aie_pkg::Q4) && live;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            acc <= aie_pkg::ACC_RST;
            flags <= aie_pkg::FLAGS_RST;
            pc_count <= 16'h0000;
        end
        else
        begin
            if (commit && to_acc)
                acc <= res;
            else if (wr_go && paddr == aie_pkg::REG_ACC)
                acc <= pwdata[7:0];
            if (commit)
                flags <= res_flags;
            else if (wr_go && paddr == aie_pkg::REG_FLAGS)
                flags <= pwdata[aie_pkg::FLAG_W-1:0];
            if (commit)
                pc_count <= 16'(pc_count + 16'h0001);
        end
    end

    // checks
    sequence s_lit_issue;
        issue && literal_add_op;
    endsequence
    sequence s_file_issue;
        issue && is_file;
    endsequence

    a_quarter_order: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == aie_pkg::Q1 |=> state == aie_pkg::Q2 ##1
        state == aie_pkg::Q3 ##1 state == aie_pkg::Q4)
        else $error("quarters out of order");
    a_lit_acc_sum: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_lit_issue |-> ##4 acc == 8'($past(acc, 4)
        + $past(instr_word[7:0], 4)))
        else $error("literal add sum wrong");
    a_other_ignored: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == aie_pkg::Q1 && !is_add |-> ##3 !pc_step && !mem_we)
        else $error("non add word executed");
    a_file_read: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_file_issue |=> mem_re ##1 !mem_re)
        else $error("file read strobe wrong");
    a_dest_file: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_file_issue |-> ##3 mem_we == $past(dw[aie_pkg::DEST_BIT], 3)
        && mem_wdata == res)
        else $error("destination choice wrong");
    a_bank_sel: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_file_issue and dw[aie_pkg::BANKSEL_BIT]
        |=> mem_addr == $past(bank_addr))
        else $error("bank pointer not used");
    a_index_mode: assert property (
        @(posedge pclk) disable iff (!presetn)
        s_file_issue and idx_mode
        |=> mem_addr == 12'($past(index_base) + {4'h0, $past(fa)}))
        else $error("indexed address wrong");
    a_carry_in: assert property (
        @(posedge pclk) disable iff (!presetn)
        state == aie_pkg::Q3 && live && file_add_carry_op
        |=> res == 8'($past(acc) + $past(operand)
        + {7'h00, $past(flags[aie_pkg::FLAG_C])}))
        else $error("carry not added");
    a_zero_flag: assert property (
        @(posedge pclk) disable iff (!presetn)
        commit |=> flags[aie_pkg::FLAG_Z] == ($past(res) == 8'h00))
        else $error("zero flag wrong");
    a_single_step: assert property (
        @(posedge pclk) disable iff (!presetn)
        pc_step |=> !pc_step [*3])
        else $error("pc stepped twice");
endmodule

// *** aie_partner.sv ***
/*
 * aie_partner: fetch unit and data memory beside aie_core.
 * assumes the bench loads words and memory bytes directly.
 */
`timescale 1ns/1ps
module aie_partner
(
    // clock and core status
    input wire logic pclk,
    input wire logic [3:0] quarter,
    // bench side
    input wire logic [15:0] fetch_word,
    input wire logic fetch_valid,
    // core side
    output logic [15:0] instr_word,
    output logic instr_valid,
    input wire logic [11:0] mem_addr,
    input wire logic mem_re,
    input wire logic mem_we,
    input wire logic [7:0] mem_wdata,
    output logic [7:0] mem_rdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] last_rd = 8'h00;
    wire in_q1 = quarter == 4'b0001;
    // word offered in q1 only; inverted elsewhere so late use shows
    assign instr_word = in_q1 ? fetch_word : ~fetch_word;
    assign instr_valid = in_q1 & fetch_valid;
    // answer only inside the strobe cycle, stale bits inverted
    assign mem_rdata = mem_re ? mem[mem_addr] : ~last_rd;
    // writes land at the edge ending q4
    always @(posedge pclk)
    begin
        if (mem_re)
            last_rd <= mem[mem_addr];
        if (mem_we)
            mem[mem_addr] <= mem_wdata;
    end
endmodule

// *** aie_pkg.sv ***
/*
 * aie_pkg: shared constants for the add instruction execute block.
 * assumes a 32-bit APB register map and a 12-bit data address.
 */
package aie_pkg;
    // instruction word fields
    localparam logic [7:0] OP_LIT = 8'h0f;
    localparam logic [5:0] OP_FADD = 6'h09;
    localparam logic [5:0] OP_FADDC = 6'h08;
    localparam int OPC_HI = 15;
    localparam int OPC_LO8 = 8;
    localparam int OPC_LO6 = 10;
    localparam int DEST_BIT = 9;
    localparam int BANKSEL_BIT = 8;
    localparam logic [7:0] INDEX_LIMIT = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hf;

    // register byte offsets
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_ACC = 8'h04;
    localparam logic [7:0] REG_FLAGS = 8'h08;
    localparam logic [7:0] REG_INDEX = 8'h0c;
    localparam logic [7:0] REG_PC = 8'h10;
    localparam logic [7:0] REG_LAST = 8'h14;

    // control field positions
    localparam int CTRL_RUN = 0;
    localparam int CTRL_EXT = 1;
    localparam int CTRL_BANK_LO = 8;

    // flag bit positions
    localparam int FLAG_C = 0;
    localparam int FLAG_DC = 1;
    localparam int FLAG_Z = 2;
    localparam int FLAG_OV = 3;
    localparam int FLAG_N = 4;
    localparam int FLAG_W = 5;

    // reset values
    localparam logic [7:0] ACC_RST = 8'h00;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [11:0] INDEX_RST = 12'h000;

    // quarter phases of one instruction cycle
    typedef enum logic [3:0] {
        Q1 = 4'b0001,
        Q2 = 4'b0010,
        Q3 = 4'b0100,
        Q4 = 4'b1000
    } aie_quarter_t;
endpackage
